// ---- core/hrac_top.v ----
// reset pad states, configuration source selection and upstream attach gating
`timescale 1ns/1ps
`default_nettype none
`include "hrac_defines.vh"

// How it works
// RULE1 - one shared transaction translator offering exactly four non-periodic buffers
// RULE2 - configuration comes from defaults or from external eeprom or spi flash
// RULE3 - external two-wire memory is 512 bytes; read it when attached
// RULE4 - no external memory found: use internal defaults everywhere
// RULE5 - with external memory, accept config updates arriving over upstream usb
// RULE6 - attach upstream only after configuration is established
// RULE7 - port power controls are active high
// RULE8 - d+ pull-up off whenever upstream supply sense is inactive
// RULE9 - after supply sense falls, remove d+ pull-up within ten seconds
// RULE10 - downstream pull-ups only while upstream vbus is powered
// RULE11 - high-impedance reset pads disable output driver and input buffer
// RULE12 - power off drives low with pull-up off; on releases driver, pull-up on
// RULE13 - latch spi speed strap at reset release, then drop pull-down, reuse as data out
// RULE14 - after power-on, check flash signature at 0xfffa; boot 0x0000 or internal rom
// RULE15 - in reset: port power low, flash select high, card pads z, detect pull-up
module hrac_top (
    input  wire                      mclk,
    input  wire                      rst_n,
    input  wire                      upstream_supply_sense,
    input  wire                      spi_speed_strap,
    input  wire                      ee_present,
    input  wire                      flash_present,
    input  wire                      src_valid,
    input  wire [7:0]                src_data,
    input  wire                      usb_upd_valid,
    input  wire [`HRAC_EE_AW-1:0]    usb_upd_addr,
    input  wire [7:0]                usb_upd_data,
    input  wire [1:0]                port_power_req,
    input  wire [`HRAC_EE_AW-1:0]    cfg_raddr,
    input  wire                      tt_alloc,
    input  wire                      tt_free,
    output reg                       src_rd_q,
    output reg  [`HRAC_SPI_AW-1:0]   src_addr_q,
    output reg                       flash_cs_low_q,
    output reg  [1:0]                port_power_ctl_q,
    output reg  [1:0]                port_power_ctl_oe_q,
    output reg  [1:0]                port_power_pu_q,
    output reg                       dp_pullup_q,
    output reg                       dn_pullup_en_q,
    output reg                       card_pad_en_q,
    output reg                       card_detect_low_pu_q,
    output reg                       strap_pd_q,
    output reg                       spi_fast_q,
    output reg                       cfg_from_ext_q,
    output reg                       boot_ext_q,
    output reg                       cfg_done_q,
    output reg                       upd_ack_q,
    output reg                       tt_avail_q,
    output reg  [`HRAC_TT_CNT_W-1:0] tt_free_cnt_q,
    output wire [7:0]                cfg_rdata_q
);
    localparam [`HRAC_DETACH_W-1:0] DETACH_CYC = `HRAC_DETACH_CYC;

    // =================================================================
    // input synchronisers (pins)
    reg [1:0] vb_s_q, strap_s_q, ee_s_q, fl_s_q;
    always @(posedge mclk) begin
        vb_s_q    <= {vb_s_q[0], upstream_supply_sense};
        strap_s_q <= {strap_s_q[0], spi_speed_strap};
        ee_s_q    <= {ee_s_q[0], ee_present};
        fl_s_q    <= {fl_s_q[0], flash_present};
    end
    wire vbus_on = vb_s_q[1];

    // =================================================================
    // configuration sequencer
    reg [2:0]                  st_q;
    reg [1:0]                  sig_idx_q;
    reg                        sig_ok_q;
    reg                        rd_pend_q;
    reg [`HRAC_EE_AW-1:0]      ld_addr_q;
    reg                        mem_we;
    reg [`HRAC_EE_AW-1:0]      mem_waddr;
    reg [7:0]                  mem_wdata;
    // flash upgrade signature bytes "2DFU"
    wire [7:0] sig_byte = (sig_idx_q == 2'h0) ? 8'h32 :
                          (sig_idx_q == 2'h1) ? 8'h44 :
                          (sig_idx_q == 2'h2) ? 8'h46 : 8'h55;

    always @* begin
        mem_we    = 1'b0;
        mem_waddr = ld_addr_q;
        mem_wdata = src_data;
        if (st_q == `HRAC_ST_LOAD && rd_pend_q && src_valid) begin
            mem_we = 1'b1; // RULE3
        end else if (st_q == `HRAC_ST_READY && cfg_from_ext_q && usb_upd_valid) begin
            mem_we    = 1'b1; // RULE5
            mem_waddr = usb_upd_addr;
            mem_wdata = usb_upd_data;
        end
    end

    hrac_cfg_mem hrac_cfg_mem_i (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (cfg_raddr),
        .rdata (cfg_rdata_q)
    );

    always @(posedge mclk) begin
        if (!rst_n) begin
            st_q           <= `HRAC_ST_RESET;
            sig_idx_q      <= 2'h0;
            sig_ok_q       <= 1'b1;
            rd_pend_q      <= 1'b0;
            ld_addr_q      <= {`HRAC_EE_AW{1'b0}};
            src_rd_q       <= 1'b0;
            src_addr_q     <= `HRAC_SPI_SIG_ADDR;
            flash_cs_low_q <= 1'b0; // RULE15
            cfg_from_ext_q <= 1'b0;
            boot_ext_q     <= 1'b0;
            cfg_done_q     <= 1'b0;
            upd_ack_q      <= 1'b0;
            spi_fast_q     <= 1'b0;
            strap_pd_q     <= 1'b1;
        end else begin
            src_rd_q  <= 1'b0;
            upd_ack_q <= mem_we && st_q == `HRAC_ST_READY;
            case (st_q)
                `HRAC_ST_RESET: begin
                    // strap caught on the first clock after release
                    spi_fast_q <= strap_s_q[1]; // RULE13
                    strap_pd_q <= 1'b0; // RULE13
                    st_q       <= `HRAC_ST_PROBE;
                end
                `HRAC_ST_PROBE: begin
                    if (fl_s_q[1]) begin
                        flash_cs_low_q <= 1'b1; // RULE14
                        src_addr_q     <= `HRAC_SPI_SIG_ADDR;
                        src_rd_q       <= 1'b1;
                        rd_pend_q      <= 1'b1;
                        st_q           <= `HRAC_ST_SIG;
                    end else if (ee_s_q[1]) begin
                        src_addr_q <= `HRAC_SPI_BOOT_ADDR;
                        src_rd_q   <= 1'b1;
                        rd_pend_q  <= 1'b1;
                        st_q       <= `HRAC_ST_LOAD; // RULE2
                    end else begin
                        cfg_from_ext_q <= 1'b0; // RULE4
                        st_q           <= `HRAC_ST_READY;
                    end
                end
                `HRAC_ST_SIG: begin
                    if (src_valid) begin
                        if (src_data != sig_byte) begin
                            sig_ok_q <= 1'b0;
                        end
                        if (sig_idx_q == `HRAC_SIG_LAST) begin
                            // signature decides boot source
                            boot_ext_q     <= sig_ok_q && src_data == sig_byte; // RULE14
                            flash_cs_low_q <= 1'b0;
                            cfg_from_ext_q <= 1'b1; // RULE2
                            rd_pend_q      <= 1'b0;
                            st_q           <= `HRAC_ST_READY;
                        end else begin
                            sig_idx_q  <= sig_idx_q + 2'h1;
                            src_addr_q <= src_addr_q + 16'h0001;
                            src_rd_q   <= 1'b1;
                        end
                    end
                end
                `HRAC_ST_LOAD: begin
                    if (src_valid) begin
                        if (ld_addr_q == `HRAC_EE_LAST) begin
                            rd_pend_q      <= 1'b0;
                            cfg_from_ext_q <= 1'b1; // RULE3
                            st_q           <= `HRAC_ST_READY;
                        end else begin
                            ld_addr_q  <= ld_addr_q + 9'h001;
                            src_addr_q <= src_addr_q + 16'h0001;
                            src_rd_q   <= 1'b1;
                        end
                    end
                end
                `HRAC_ST_READY: begin
                    cfg_done_q <= 1'b1; // RULE6
                end
                default: st_q <= `HRAC_ST_RESET;
            endcase
        end
    end

    // =================================================================
    // upstream attach and detach timing
    // detach is immediate; the saturating counter is only a backstop at ten seconds
    reg [`HRAC_DETACH_W-1:0] off_cnt_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            dp_pullup_q    <= 1'b0;
            dn_pullup_en_q <= 1'b0;
            off_cnt_q      <= {`HRAC_DETACH_W{1'b0}};
        end else begin
            dp_pullup_q    <= vbus_on && cfg_done_q && off_cnt_q < DETACH_CYC; // RULE6 RULE8 RULE9
            dn_pullup_en_q <= vbus_on; // RULE10
            off_cnt_q      <= vbus_on ? {`HRAC_DETACH_W{1'b0}} :
                              (off_cnt_q == DETACH_CYC) ? off_cnt_q :
                              off_cnt_q + 32'h00000001;
        end
    end

    // =================================================================
    // pads: port power, card interface
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            always @(posedge mclk) begin
                if (!rst_n) begin
                    port_power_ctl_q[p]    <= 1'b0; // RULE15
                    port_power_ctl_oe_q[p] <= 1'b1;
                    port_power_pu_q[p]     <= 1'b0;
                end else begin
                    // high level means port powered; open drain when on
                    port_power_ctl_q[p]    <= 1'b0; // RULE7
                    port_power_ctl_oe_q[p] <= ~port_power_req[p]; // RULE12
                    port_power_pu_q[p]     <= port_power_req[p]; // RULE12
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (!rst_n) begin
            card_pad_en_q        <= 1'b0; // RULE11 RULE15
            card_detect_low_pu_q <= 1'b1; // RULE15
        end else begin
            card_pad_en_q        <= cfg_done_q;
            card_detect_low_pu_q <= 1'b1;
        end
    end

    // =================================================================
    // transaction translator buffer pool
    always @(posedge mclk) begin
        if (!rst_n) begin
            tt_free_cnt_q <= `HRAC_TT_NP_BUFS; // RULE1
            tt_avail_q    <= 1'b1;
        end else begin
            if (tt_alloc && !tt_free && tt_free_cnt_q != 3'h0) begin
                tt_free_cnt_q <= tt_free_cnt_q - 3'h1;
                tt_avail_q    <= tt_free_cnt_q != 3'h1;
            end else if (tt_free && !tt_alloc && tt_free_cnt_q != `HRAC_TT_NP_BUFS) begin
                tt_free_cnt_q <= tt_free_cnt_q + 3'h1; // RULE1
                tt_avail_q    <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/hrac_defines.vh ----
// constants for the hub reset and attach control block
`ifndef HRAC_DEFINES_VH
`define HRAC_DEFINES_VH

// =====================================================================
// transaction translator
`define HRAC_TT_NP_BUFS      3'h4
`define HRAC_TT_CNT_W        3

// =====================================================================
// configuration memory
`define HRAC_EE_DEPTH        512
`define HRAC_EE_AW           9
`define HRAC_EE_LAST         9'h1ff
`define HRAC_SPI_AW          16
`define HRAC_SPI_SIG_ADDR    16'hfffa
`define HRAC_SPI_BOOT_ADDR   16'h0000
`define HRAC_SIG_LEN         3'h4
`define HRAC_SIG_LAST        2'h3

// =====================================================================
// timing: clock period in ps, detach limit in ms
`define HRAC_CLK_PS          5000
`define HRAC_DETACH_MS       10000
`define HRAC_PS_PER_MS       1000000000
// ten seconds of 5 ns cycles, 2000000000, well below the top of the 32-bit counter
`define HRAC_DETACH_CYC      32'h77359400
`define HRAC_DETACH_W        32

// =====================================================================
// sequencer states
`define HRAC_ST_RESET        3'h0
`define HRAC_ST_PROBE        3'h1
`define HRAC_ST_SIG          3'h2
`define HRAC_ST_LOAD         3'h3
`define HRAC_ST_READY        3'h4

`endif

// ---- core/hrac_cfg_mem.v ----
// small configuration store, 512 bytes, registered read
`timescale 1ns/1ps
`default_nettype none
`include "hrac_defines.vh"

module hrac_cfg_mem (
    input  wire                    mclk,
    input  wire                    we,
    input  wire [`HRAC_EE_AW-1:0]  waddr,
    input  wire [7:0]              wdata,
    input  wire [`HRAC_EE_AW-1:0]  raddr,
    output reg  [7:0]              rdata
);
    reg [7:0] mem [0:`HRAC_EE_DEPTH-1];

    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- tb/hrac_top_monitor.sv ----
// assertions on the pins of the hub reset and attach block
`timescale 1ns/1ps
`default_nettype none

module hrac_top_monitor (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       upstream_supply_sense,
    input wire logic       usb_upd_valid,
    input wire logic [1:0] port_power_req,
    input wire logic [1:0] port_power_ctl_q,
    input wire logic [1:0] port_power_ctl_oe_q,
    input wire logic [1:0] port_power_pu_q,
    input wire logic       flash_cs_low_q,
    input wire logic       dp_pullup_q,
    input wire logic       dn_pullup_en_q,
    input wire logic       card_pad_en_q,
    input wire logic       card_detect_low_pu_q,
    input wire logic       strap_pd_q,
    input wire logic       cfg_from_ext_q,
    input wire logic       cfg_done_q,
    input wire logic       upd_ack_q,
    input wire logic       tt_avail_q,
    input wire logic [2:0] tt_free_cnt_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ========
    // pads and port power
    a_reset_pad_state: assert property (disable iff (1'b0)
        !rst_n |=> {port_power_ctl_oe_q, flash_cs_low_q, card_pad_en_q,
                    card_detect_low_pu_q, strap_pd_q} == 6'h33)
        else $error("pads not in reset state");
    a_power_drive_low: assert property (
        (port_power_ctl_oe_q & port_power_pu_q) == 2'h0 && port_power_ctl_q == 2'h0)
        else $error("port driver and pull-up both on");
    a_power_on_high: assert property (
        (cfg_done_q && port_power_req[0])[*6] |-> port_power_pu_q[0] && !port_power_ctl_oe_q[0])
        else $error("port power not enabled");

    // ========
    // attach gating, update gating and buffer count
    a_pullup_needs_vbus: assert property (
        !upstream_supply_sense[*4] |-> !dp_pullup_q)
        else $error("d+ pull-up without supply");
    a_detach_bound: assert property (
        $fell(upstream_supply_sense) |-> ##[1:4] !dp_pullup_q)
        else $error("d+ pull-up kept after supply loss");
    a_downstream_gate: assert property (
        $fell(upstream_supply_sense) ##1 !upstream_supply_sense[*3] |-> !dn_pullup_en_q)
        else $error("downstream pull-ups without supply");
    a_attach_after_cfg: assert property (
        dp_pullup_q |-> cfg_done_q && $past(cfg_done_q))
        else $error("attach before configuration");
    a_update_gated: assert property (
        upd_ack_q |-> cfg_from_ext_q && ($past(usb_upd_valid) || $past(usb_upd_valid, 2)))
        else $error("update acknowledged without cause");
    a_tt_bound: assert property (
        tt_free_cnt_q <= 3'h4 && tt_avail_q == (tt_free_cnt_q != 3'h0))
        else $error("buffer count out of range");

    c_ext_config: cover property (cfg_done_q && cfg_from_ext_q);
    c_update: cover property (upd_ack_q);
    c_detach: cover property ($fell(dp_pullup_q));
endmodule

bind hrac_top hrac_top_monitor hrac_top_monitor_i (
    .mclk, .rst_n, .upstream_supply_sense, .usb_upd_valid, .port_power_req,
    .port_power_ctl_q, .port_power_ctl_oe_q, .port_power_pu_q, .flash_cs_low_q,
    .dp_pullup_q, .dn_pullup_en_q, .card_pad_en_q, .card_detect_low_pu_q, .strap_pd_q,
    .cfg_from_ext_q, .cfg_done_q, .upd_ack_q, .tt_avail_q, .tt_free_cnt_q
);
`default_nettype wire

// ---- tb/hrac_mem_model.sv ----
// external configuration memory answering the block's byte reads
`timescale 1ns/1ps
`default_nettype none

module hrac_mem_model (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        src_rd_q,
    input  wire logic [15:0] src_addr_q,
    output var  logic        src_valid,
    output var  logic [7:0]  src_data
);
    logic [15:0] addr_q;
    int          wait_q = -1;

    function automatic logic [7:0] byte_at(input logic [15:0] a);
        case (a)
            16'hfffa: return 8'h32;
            16'hfffb: return 8'h44;
            16'hfffc: return 8'h46;
            16'hfffd: return 8'h55;
            default:  return a[7:0] ^ 8'h5a;
        endcase
    endfunction

    initial begin
        src_valid = 1'b0;
        src_data = 8'h00;
    end

    // idle data toggles so a stale byte is never mistaken for an answer
    always @(posedge mclk) begin
        src_valid <= 1'b0;
        src_data <= ~src_data;
        if (src_rd_q) begin
            addr_q <= src_addr_q;
            wait_q <= slow ? 3 : 0;
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end else if (wait_q == 0) begin
            src_valid <= 1'b1;
            src_data <= byte_at(addr_q);
            wait_q <= -1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/hub_reset_attach_control_test.sv ----
// self-checking bench for the hub reset and attach block
`timescale 1ns/1ps
`default_nettype none

module hub_reset_attach_control_test;
    logic        mclk, rst_n, upstream_supply_sense, spi_speed_strap, slow;
    logic        ee_present, flash_present, src_valid, usb_upd_valid, tt_alloc, tt_free;
    logic [7:0]  src_data, usb_upd_data, cfg_rdata_q;
    logic [8:0]  usb_upd_addr, cfg_raddr;
    logic [1:0]  port_power_req, port_power_ctl_q, port_power_ctl_oe_q, port_power_pu_q;
    logic        src_rd_q, flash_cs_low_q, dp_pullup_q, dn_pullup_en_q, card_pad_en_q;
    logic        card_detect_low_pu_q, strap_pd_q, spi_fast_q, cfg_from_ext_q;
    logic        boot_ext_q, cfg_done_q, upd_ack_q, tt_avail_q;
    logic [15:0] src_addr_q, reads;
    logic [2:0]  tt_free_cnt_q;
    int          mismatches, comparisons, cycles;

    hrac_top hrac_top_i (
        .mclk, .rst_n, .upstream_supply_sense, .spi_speed_strap, .ee_present,
        .flash_present, .src_valid, .src_data, .usb_upd_valid, .usb_upd_addr,
        .usb_upd_data, .port_power_req, .cfg_raddr, .tt_alloc, .tt_free, .src_rd_q,
        .src_addr_q, .flash_cs_low_q, .port_power_ctl_q, .port_power_ctl_oe_q,
        .port_power_pu_q, .dp_pullup_q, .dn_pullup_en_q, .card_pad_en_q,
        .card_detect_low_pu_q, .strap_pd_q, .spi_fast_q, .cfg_from_ext_q, .boot_ext_q,
        .cfg_done_q, .upd_ack_q, .tt_avail_q, .tt_free_cnt_q, .cfg_rdata_q
    );
    hrac_mem_model hrac_mem_model_i (
        .mclk, .slow, .src_rd_q, .src_addr_q, .src_valid, .src_data
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (!rst_n) reads <= 16'h0000;
        else if (src_rd_q === 1'b1) reads <= reads + 16'h0001;
        if (cycles == 12000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ========
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset(input logic s, input logic f, input logic e);
        rst_n = 1'b0;
        spi_speed_strap = s;
        flash_present = f;
        ee_present = e;
        repeat (16) @(negedge mclk);
        check({port_power_ctl_oe_q, port_power_ctl_q, flash_cs_low_q, card_pad_en_q,
               card_detect_low_pu_q, strap_pd_q, dp_pullup_q}, 16'h0186);
        rst_n = 1'b1;
        for (int i = 0; i < 4000 && cfg_done_q !== 1'b1; i++) @(negedge mclk);
    endtask

    task automatic send_update(input logic exp);
        logic seen;
        seen = 1'b0;
        usb_upd_addr = 9'h1ff;
        usb_upd_valid = 1'b1;
        // the acknowledge stands one cycle only, so look from the first edge on
        repeat (3) begin
            @(negedge mclk);
            usb_upd_valid = 1'b0;
            seen = seen | upd_ack_q;
        end
        check(seen, exp);
    endtask

    task automatic read_cfg(input logic [8:0] a, input logic [7:0] exp);
        cfg_raddr = a;
        repeat (2) @(negedge mclk);
        check(cfg_rdata_q, exp);
    endtask

    task automatic tt_pulse(input logic a, input logic f, input int n);
        tt_alloc = a;
        tt_free = f;
        repeat (n) @(negedge mclk);
        tt_alloc = 1'b0;
        tt_free = 1'b0;
        @(negedge mclk);
    endtask

    // ========
    // scenarios
    task automatic t_defaults;
        do_reset(1'b0, 1'b0, 1'b0);
        check({cfg_done_q, cfg_from_ext_q, boot_ext_q, spi_fast_q, strap_pd_q}, 16'h10);
        check(reads, 16'h0000);
        send_update(1'b0);
        check({card_pad_en_q, card_detect_low_pu_q}, 16'h3);
        tt_pulse(1'b1, 1'b0, 5);
        check({tt_avail_q, tt_free_cnt_q}, 16'h0);
        tt_pulse(1'b0, 1'b1, 1);
        tt_pulse(1'b1, 1'b1, 2);
        check({tt_avail_q, tt_free_cnt_q}, 16'h9);
        tt_pulse(1'b0, 1'b1, 5);
        check({tt_avail_q, tt_free_cnt_q}, 16'hc);
        $display("defaults and buffer test done");
    endtask

    task automatic t_flash;
        slow = 1'b1;
        do_reset(1'b1, 1'b1, 1'b0);
        check({cfg_done_q, cfg_from_ext_q, boot_ext_q, spi_fast_q, strap_pd_q}, 16'h1e);
        check(reads, 16'h0004);
        check(flash_cs_low_q, 16'h0);
        $display("flash test done");
    endtask

    task automatic t_eeprom;
        slow = 1'b0;
        upstream_supply_sense = 1'b1;
        do_reset(1'b0, 1'b0, 1'b1);
        check({cfg_done_q, cfg_from_ext_q, boot_ext_q}, 16'h6);
        check(reads, 16'h0200);
        read_cfg(9'h010, 8'h4a);
        read_cfg(9'h1ff, 8'ha5);
        send_update(1'b1);
        read_cfg(9'h1ff, 8'h3c);
        upstream_supply_sense = 1'b0;
        repeat (4) @(negedge mclk);
        check({dp_pullup_q, dn_pullup_en_q}, 16'h0);
        upstream_supply_sense = 1'b1;
        repeat (6) @(negedge mclk);
        check({dp_pullup_q, dn_pullup_en_q}, 16'h3);
        for (int r = 0; r < 4; r++) begin
            port_power_req = r[1:0];
            repeat (6) @(negedge mclk);
            check({port_power_pu_q, port_power_ctl_oe_q, port_power_ctl_q},
                  {10'h0, r[1:0], ~r[1:0], 2'h0});
        end
        $display("eeprom, attach and power test done");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {upstream_supply_sense, usb_upd_valid, tt_alloc, tt_free, slow} = 5'h00;
        usb_upd_addr = 9'h000;
        usb_upd_data = 8'h3c;
        cfg_raddr = 9'h000;
        port_power_req = 2'h0;
        t_defaults();
        t_flash();
        t_eeprom();
        report_and_stop();
    end
endmodule
`default_nettype wire
